// [src/lpwk_cfg.svh]
// register offsets, field positions, reset values and timing for wake logic
`ifndef LPWK_CFG_SVH
`define LPWK_CFG_SVH
`define LPWK_ADDR_W 8
`define LPWK_OFF_PIN_STAT 8'h1C
`define LPWK_OFF_PIN_EN 8'h20
`define LPWK_OFF_PER_STAT 8'h30
`define LPWK_OFF_PER_EN 8'h34
`define LPWK_OFF_CTRL 8'h38
`define LPWK_PIN_CNT 2
`define LPWK_PIN_MASK 32'h0000_0003
`define LPWK_PER_STAT_MASK 32'h0003_0010
`define LPWK_PER_EN_MASK 32'h07F8_0010
`define LPWK_BIT_EXTRST 17
`define LPWK_BIT_BACKUP 16
`define LPWK_BIT_CMP0 4
`define LPWK_BIT_LPCMP 26
`define LPWK_BIT_SERIAL_PERIPH_ONE_WAKE_ALLOW 25
`define LPWK_BIT_AUDIO 24
`define LPWK_BIT_TW2 23
`define LPWK_BIT_TW1 22
`define LPWK_BIT_TW0 21
`define LPWK_BIT_LPUART 20
`define LPWK_BIT_ASYNC_PORT_TWO_WAKE_ALLOW 19
`define LPWK_PER_LO 19
`define LPWK_PER_CNT 8
`define LPWK_RESET_VAL 32'h0000_0000
`define LPWK_CLK_NS 40
`define LPWK_WAKE_HOLD_NS 80
`define LPWK_WAKE_HOLD_CYC ((`LPWK_WAKE_HOLD_NS + `LPWK_CLK_NS - 1) / `LPWK_CLK_NS)
`endif

// [src/lpwk_pkg.sv]
// types shared by the wake-up source logic
package lpwk_pkg;
    // power state seen by the wake sequencer
    typedef enum logic [1:0]
    {
        LPWK_ACTIVE = 2'b00,
        LPWK_ASLEEP = 2'b01,
        LPWK_WAKING = 2'b11
    } lpwk_state_e;
    typedef logic [31:0] lpwk_word_t;
endpackage

// [src/lpwk_edge_det.sv]
// pin transition detector for the wake pins
`timescale 1ns/1ps
module lpwk_edge_det
#(
    parameter int W = 2
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinToggle
);
    logic [W-1:0] pinLast_q; // previous pin sample
    logic [W-1:0] pinLast_d;
    logic primed_q; // first sample taken
    logic primed_d;

    // next sample and ready flag
    always_comb
    begin
        pinLast_d = pinIn;
        primed_d = 1'b1;
    end

    // register samples
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pinLast_q <= '0;
            primed_q <= 1'b0;
        end
        else
        begin
            pinLast_q <= pinLast_d;
            primed_q <= primed_d;
        end
    end

    // either direction counts; no edge before first sample
    assign pinToggle = primed_q ? (pinIn ^ pinLast_q) : '0;
endmodule

// [src/lpwk_wake_src.sv]
// wake-up source logic: pin and peripheral wake enables and status
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`include "lpwk_cfg.svh"
module lpwk_wake_src
    import lpwk_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`LPWK_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    input wire logic [`LPWK_PIN_CNT-1:0] pinPortThree,
    input wire logic lowpowerComparatorIrq,
    input wire logic serialPeriphOneIrq,
    input wire logic audioSerialIrq,
    input wire logic twowireTwoIrq,
    input wire logic twowireOneIrq,
    input wire logic twowireZeroIrq,
    input wire logic lowpowerAsyncPortIrq,
    input wire logic asyncPortTwoIrq,
    input wire logic extResetWake,
    input wire logic backupWake,
    input wire logic comparatorZeroTrig,
    input wire logic sleepReq,
    output logic wakeReq,
    output logic deviceAsleep
);
    // register file state
    lpwk_word_t pinEn_q; // gpio_port3_wake_enable
    lpwk_word_t pinEn_d;
    lpwk_word_t pinStat_q; // gpio_port3_wake_status
    lpwk_word_t pinStat_d;
    lpwk_word_t perStat_q; // peripheral_wake_status
    lpwk_word_t perStat_d;
    lpwk_word_t perEn_q; // peripheral_wake_enable
    lpwk_word_t perEn_d;
    logic gpioWakePermit_q; // system_power_mgmt_reg pin wake permit
    logic gpioWakePermit_d;
    // read path
    lpwk_word_t rdata_q; // read data register
    lpwk_word_t rdata_d;
    // power sequencing
    lpwk_state_e state_q; // power state
    lpwk_state_e state_d;
    // counts down the remaining wake cycles
    logic [1:0] holdCnt_q; // wake pulse stretch
    logic [1:0] holdCnt_d;
    // decoded events and wake terms
    logic [`LPWK_PIN_CNT-1:0] pinToggle; // per pin transition
    logic [`LPWK_PER_CNT-1:0] perIrq; // peripheral irq vector
    logic [`LPWK_PER_CNT-1:0] perAllow; // peripheral enable slice
    lpwk_word_t pinSet; // hardware set for pin status
    lpwk_word_t perSet; // hardware set for peripheral status
    logic pinWakeHit; // enabled pin event pending
    logic perWakeHit; // enabled peripheral irq
    logic wakeCause; // any wake cause

    // write-one-to-clear with hardware set priority
    // set is applied after clear, so an event in the write cycle survives
    // bits outside the mask never hold a one
    function automatic lpwk_word_t w1c(input lpwk_word_t cur,
                                       input lpwk_word_t set,
                                       input lpwk_word_t clr,
                                       input lpwk_word_t mask);
        w1c = ((cur & ~clr) | set) & mask;
    endfunction

    // address match with write or read strobe
    // one decoder shared by every register write
    function automatic logic hit(input logic stb,
                                 input logic [`LPWK_ADDR_W-1:0] a,
                                 input logic [`LPWK_ADDR_W-1:0] off);
        hit = stb && (a == off);
    endfunction

    // transition detector, silent on the first cycle after reset
    // so a pin already high at release is not taken as an edge
    lpwk_edge_det #(.W(`LPWK_PIN_CNT)) pinEdges
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .pinIn(pinPortThree),
        .pinToggle(pinToggle)
    );

    // peripheral irq order follows enable bits 19 up to 26
    // irq lines are live levels, not latched here;
    // a source must hold its line until the wake is taken
    assign perIrq = {lowpowerComparatorIrq,
                     serialPeriphOneIrq,
                     audioSerialIrq,
                     twowireTwoIrq,
                     twowireOneIrq,
                     twowireZeroIrq,
                     lowpowerAsyncPortIrq,
                     asyncPortTwoIrq};
    assign perAllow = perEn_q[`LPWK_BIT_LPCMP:`LPWK_PER_LO];

    // hardware sets for status registers
    // pin toggles count in any power state, enabled or not
    // each event input sets its flag for every cycle it is high
    always_comb
    begin
        pinSet = '0;
        pinSet[`LPWK_PIN_CNT-1:0] = pinToggle;
        // peripheral flags: reset, backup and comparator zero
        perSet = '0;
        perSet[`LPWK_BIT_EXTRST] = extResetWake;
        perSet[`LPWK_BIT_BACKUP] = backupWake;
        perSet[`LPWK_BIT_CMP0] = comparatorZeroTrig;
    end

    // wake decision: pins need status, enable and permit; irq lines and comparator zero need a live event and enable; reset and backup never wake
    // pins wake from latched status, so a short toggle is not lost
    // peripherals wake from the live line and their enable bit
    // comparator zero wakes only while its enable bit is set
    always_comb
    begin
        pinWakeHit = gpioWakePermit_q
            && |(pinStat_q[`LPWK_PIN_CNT-1:0]
                 & pinEn_q[`LPWK_PIN_CNT-1:0]);
        perWakeHit = |(perIrq & perAllow);
        wakeCause = pinWakeHit || perWakeHit
            || (perEn_q[`LPWK_BIT_CMP0] && comparatorZeroTrig);
    end

    // register writes and status updates
    // enables are plain read-write, masked to implemented bits
    // unmapped addresses fall through and change nothing
    always_comb
    begin
        pinEn_d = pinEn_q;
        perEn_d = perEn_q;
        gpioWakePermit_d = gpioWakePermit_q;
        // pin enables, absent pins dropped
        if (hit(regWrite, regAddr, `LPWK_OFF_PIN_EN))
        begin
            pinEn_d = regWdata & `LPWK_PIN_MASK;
        end
        // peripheral enables, reserved bits dropped
        if (hit(regWrite, regAddr, `LPWK_OFF_PER_EN))
        begin
            perEn_d = regWdata & `LPWK_PER_EN_MASK;
        end
        // global pin wake permission
        if (hit(regWrite, regAddr, `LPWK_OFF_CTRL))
        begin
            gpioWakePermit_d = regWdata[0];
        end
        // pin status: toggles set, written ones clear
        pinStat_d = w1c(pinStat_q, pinSet,
            hit(regWrite, regAddr, `LPWK_OFF_PIN_STAT) ? regWdata : '0,
            `LPWK_PIN_MASK);
        // peripheral status: events set, written ones clear
        perStat_d = w1c(perStat_q, perSet,
            hit(regWrite, regAddr, `LPWK_OFF_PER_STAT) ? regWdata : '0,
            `LPWK_PER_STAT_MASK);
    end

    // read mux, unmapped reads return zero
    // the word is registered, so it stands the cycle after the strobe
    // and no other, keeping the bus quiet between reads
    always_comb
    begin
        // zero unless a read is asked for
        rdata_d = '0;
        if (regRead)
        begin
            case (regAddr)
                `LPWK_OFF_PIN_STAT: rdata_d = pinStat_q;
                `LPWK_OFF_PIN_EN: rdata_d = pinEn_q;
                `LPWK_OFF_PER_STAT: rdata_d = perStat_q;
                `LPWK_OFF_PER_EN: rdata_d = perEn_q;
                `LPWK_OFF_CTRL: rdata_d = {31'h0000_0000, gpioWakePermit_q};
                default: rdata_d = '0; // unmapped
            endcase
        end
    end

    // power state: sleep until an enabled cause, then hold wake
    // the wake request is stretched so a slow consumer sees it
    // a cause present while active is ignored until the next sleep
    always_comb
    begin
        state_d = state_q;
        holdCnt_d = holdCnt_q;
        case (state_q)
            // running, waits for a sleep request
            LPWK_ACTIVE:
            begin
                if (sleepReq)
                begin
                    state_d = LPWK_ASLEEP;
                end
            end
            // low power, waits for an enabled cause
            LPWK_ASLEEP:
            begin
                if (wakeCause)
                begin
                    state_d = LPWK_WAKING;
                    holdCnt_d = 2'(`LPWK_WAKE_HOLD_CYC - 1);
                end
            end
            // wake request held for the stretch count
            LPWK_WAKING:
            begin
                if (holdCnt_q == 2'h0)
                begin
                    state_d = LPWK_ACTIVE;
                end
                else
                begin
                    holdCnt_d = holdCnt_q - 2'h1;
                end
            end
            // unused code falls back to running
            default:
            begin
                state_d = LPWK_ACTIVE;
            end
        endcase
    end

    // register file: enables, status flags and pin wake permit
    // every implemented field comes out of reset as zero
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pinEn_q <= `LPWK_RESET_VAL;
            perEn_q <= `LPWK_RESET_VAL;
            pinStat_q <= `LPWK_RESET_VAL;
            perStat_q <= `LPWK_RESET_VAL;
            gpioWakePermit_q <= 1'b0; // permission closed
        end
        else
        begin
            pinEn_q <= pinEn_d;
            perEn_q <= perEn_d;
            pinStat_q <= pinStat_d;
            perStat_q <= perStat_d;
            gpioWakePermit_q <= gpioWakePermit_d;
        end
    end

    // read data register: one cycle after the strobe
    // back to zero on any other cycle, so stale words never stand
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rdata_q <= `LPWK_RESET_VAL; // quiet bus
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // power state and wake stretch counter
    // the device comes out of reset running
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= LPWK_ACTIVE;
            holdCnt_q <= 2'h0;
        end
        else
        begin
            state_q <= state_d;
            holdCnt_q <= holdCnt_d;
        end
    end

    // read data comes straight from a flop; wake and asleep flags are decoded from state_q
    // wake request and asleep flag never stand together
    assign regRdata = rdata_q;
    assign wakeReq = (state_q == LPWK_WAKING);
    assign deviceAsleep = (state_q == LPWK_ASLEEP);
endmodule

// [tb/lpwk_wake_src_props.sv]
// assertions on the wake-up source logic ports
`timescale 1ns/1ps
`include "lpwk_cfg.svh"
module lpwk_wake_src_props
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [`LPWK_ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic [1:0] pinPortThree,
    input wire logic lowpowerComparatorIrq,
    input wire logic serialPeriphOneIrq,
    input wire logic audioSerialIrq,
    input wire logic twowireTwoIrq,
    input wire logic twowireOneIrq,
    input wire logic twowireZeroIrq,
    input wire logic lowpowerAsyncPortIrq,
    input wire logic asyncPortTwoIrq,
    input wire logic extResetWake,
    input wire logic backupWake,
    input wire logic wakeReq,
    input wire logic deviceAsleep
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [31:0] perEn_q; // shadow of peripheral enables
    logic [1:0] pinEn_q; // shadow of pin enables
    logic [1:0] pinOld_q; // pin levels one cycle back
    wire [7:0] irqs = {lowpowerComparatorIrq, serialPeriphOneIrq,
        audioSerialIrq, twowireTwoIrq, twowireOneIrq, twowireZeroIrq,
        lowpowerAsyncPortIrq, asyncPortTwoIrq};
    wire [1:0] pinTog = pinPortThree ^ pinOld_q;
    wire rdSt = regRead && regAddr == `LPWK_OFF_PER_STAT;
    wire wrSt = regWrite && regAddr == `LPWK_OFF_PER_STAT;
    // track enable writes so wake decisions can be predicted
    always_ff @(posedge clk)
    begin
        pinOld_q <= pinPortThree;
        if (sys_rst)
        begin
            perEn_q <= 32'h0;
            pinEn_q <= 2'h0;
        end
        else if (regWrite && regAddr == `LPWK_OFF_PER_EN)
            perEn_q <= regWdata & `LPWK_PER_EN_MASK;
        else if (regWrite && regAddr == `LPWK_OFF_PIN_EN)
            pinEn_q <= regWdata[1:0];
    end
    chk_en_readback: assert property (
        regWrite && regAddr == `LPWK_OFF_PER_EN ##1 regRead
        && regAddr == `LPWK_OFF_PER_EN
        |=> regRdata == ($past(regWdata, 2) & `LPWK_PER_EN_MASK))
        else $error("enable readback wrong");
    chk_pin_status: assert property (
        pinTog != 2'h0 ##1 regRead && regAddr == `LPWK_OFF_PIN_STAT
        |=> (regRdata[1:0] & $past(pinTog, 2)) == $past(pinTog, 2))
        else $error("pin status not set");
    chk_irq_wake: assert property (
        deviceAsleep && (irqs & perEn_q[26:19]) != 8'h0
        |=> wakeReq && !deviceAsleep) else $error("no wake");
    chk_masked_quiet: assert property (
        deviceAsleep && perEn_q == 0 && pinEn_q == 0 && !extResetWake
        && !backupWake |=> !wakeReq) else $error("masked wake");
    chk_wake_hold: assert property (
        $rose(wakeReq) |-> wakeReq [*2] ##1 !wakeReq)
        else $error("wake pulse length");
    chk_ext_flag: assert property (
        extResetWake ##1 rdSt |=> regRdata[17]) else $error("flag 17");
    chk_backup_flag: assert property (
        backupWake ##1 rdSt |=> regRdata[16]) else $error("flag 16");
    chk_w1c_clear: assert property (
        wrSt && regWdata[17] && !extResetWake ##1 rdSt |=> !regRdata[17])
        else $error("flag 17 not cleared");
    cover property ($rose(wakeReq));
    cover property (deviceAsleep && pinTog != 2'h0);
    cover property (rdSt ##1 regRdata[16]);
endmodule

// [tb/lpwk_far_side.sv]
// far side model: port-three pins and peripheral interrupt lines
`timescale 1ns/1ps
module lpwk_far_side
(
    input wire logic clk,
    input wire logic [1:0] pinCmd,
    input wire logic [7:0] irqCmd,
    output logic [1:0] pinLevel = 2'h0,
    output logic [7:0] irqLevel = 8'h00
);
    // lines move just after an edge, interrupts are held levels
    always @(posedge clk)
    begin
        pinLevel <= pinCmd;
        irqLevel <= irqCmd;
    end
endmodule

// [tb/lpwk_wake_src_test.sv]
// self-checking bench for the wake-up source logic
`timescale 1ns/1ps
`include "lpwk_cfg.svh"
module lpwk_wake_src_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0, regRead = 1'b0, sleepReq = 1'b0;
    logic extResetWake = 1'b0, backupWake = 1'b0, comparatorZeroTrig = 1'b0;
    logic [1:0] pinCmd = 2'h0;
    logic [7:0] irqCmd = 8'h00;
    logic [1:0] pinLevel;
    logic [7:0] irqLevel;
    logic [31:0] regRdata;
    logic wakeReq, deviceAsleep;
    int err_total = 0, check_count = 0, cycles = 0;
    always #20 clk = ~clk;
    lpwk_far_side far (.clk(clk), .pinCmd(pinCmd), .irqCmd(irqCmd),
        .pinLevel(pinLevel), .irqLevel(irqLevel));
    lpwk_wake_src uut (.*, .pinPortThree(pinLevel),
        .lowpowerComparatorIrq(irqLevel[7]), .serialPeriphOneIrq(irqLevel[6]),
        .audioSerialIrq(irqLevel[5]), .twowireTwoIrq(irqLevel[4]),
        .twowireOneIrq(irqLevel[3]), .twowireZeroIrq(irqLevel[2]),
        .lowpowerAsyncPortIrq(irqLevel[1]), .asyncPortTwoIrq(irqLevel[0]));
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk($sformatf("register %h", a), exp, regRdata);
    endtask
    // write then read back with no gap; f drives the reset, backup and
    // comparator zero events during the write cycle
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d,
        input logic [2:0] f, input logic [31:0] exp);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        {extResetWake, backupWake, comparatorZeroTrig} <= f;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b1;
        {extResetWake, backupWake, comparatorZeroTrig} <= 3'h0;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk($sformatf("readback %h", a), exp, regRdata);
    endtask
    // enter sleep and confirm the asleep flag
    task automatic sleep_now();
        @(posedge clk);
        sleepReq <= 1'b1;
        @(posedge clk);
        sleepReq <= 1'b0;
        #1 chk("asleep", 32'h1, {31'h0, deviceAsleep});
    endtask
    // watch six cycles for a wake request
    task automatic wake_seen(input logic [31:0] exp);
        logic seen;
        seen = 1'b0;
        repeat (6)
        begin
            @(posedge clk);
            #1 seen = seen | (wakeReq === 1'b1);
        end
        chk("wake", exp, {31'h0, seen});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            finish_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 8'h1C; a <= 8'h3C; a += 4) rd(a[7:0], 32'h0);
        wr(8'h3C, 32'hFFFFFFFF);
        rd(8'h3C, 32'h0);
        wr(`LPWK_OFF_PIN_EN, 32'hFFFFFFFF);
        rd(`LPWK_OFF_PIN_EN, 32'h3);
        wr_rd(`LPWK_OFF_PER_EN, 32'hFFFF_FFFF, 3'h0, 32'h07F8_0010);
        wr(`LPWK_OFF_PIN_EN, 32'h0);
        $display("register test done");
        for (int i = 0; i < 8; i++)
        begin
            wr(`LPWK_OFF_PER_EN, 32'h0);
            sleep_now();
            irqCmd <= 8'h01 << i;
            wake_seen(32'h0);
            wr(`LPWK_OFF_PER_EN, 32'h1 << (19 + i));
            wake_seen(32'h1);
            irqCmd <= 8'h00;
        end
        $display("peripheral wake test done");
        wr(`LPWK_OFF_PER_EN, 32'h0);
        wr(`LPWK_OFF_PIN_EN, 32'h1);
        wr(`LPWK_OFF_CTRL, 32'h1);
        sleep_now();
        pinCmd <= 2'h2;
        wake_seen(32'h0);
        rd(`LPWK_OFF_PIN_STAT, 32'h2);
        wr(`LPWK_OFF_PIN_STAT, 32'h1);
        rd(`LPWK_OFF_PIN_STAT, 32'h2);
        wr(`LPWK_OFF_PIN_STAT, 32'h2);
        rd(`LPWK_OFF_PIN_STAT, 32'h0);
        pinCmd <= 2'h3;
        wake_seen(32'h1);
        pinCmd <= 2'h1;
        repeat (1) @(posedge clk);
        rd(`LPWK_OFF_PIN_STAT, 32'h3);
        $display("pin wake test done");
        wr_rd(`LPWK_OFF_PER_STAT, 32'h0, 3'h4, 32'h0002_0000);
        wr_rd(`LPWK_OFF_PER_STAT, 32'h0, 3'h2, 32'h0003_0000);
        wr_rd(`LPWK_OFF_PER_STAT, 32'h0, 3'h1, 32'h0003_0010);
        wr_rd(`LPWK_OFF_PER_STAT, 32'h0002_0000, 3'h0, 32'h0001_0010);
        wr_rd(`LPWK_OFF_PER_STAT, 32'h0001_0000, 3'h2, 32'h0001_0010);
        $display("status flag test done");
        finish_test();
    end
endmodule
bind lpwk_wake_src lpwk_wake_src_props chk (.*);
